// >>> crcbe_pkg.sv
// constants shared by the byte-serial crc engine
package crcbe_pkg;

    // ----------------------------------------------------------------
    // register addresses on the special-function-register bus
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_ADDR    = 8'h84;
    localparam logic [7:0]  INPUT_ADDR   = 8'h85;
    localparam logic [7:0]  DATA_ADDR    = 8'h86;
    localparam logic [7:0]  FLIP_ADDR    = 8'h87;

    // ----------------------------------------------------------------
    // control register layout and reset values
    // ----------------------------------------------------------------
    localparam int          SEL_BIT      = 4;
    localparam int          INIT_BIT     = 3;
    localparam int          VAL_BIT      = 2;
    localparam int          PTR_LSB      = 0;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [7:0]  RDATA_RESET  = 8'h00;
    localparam logic [7:0]  FLIP_RESET   = 8'h00;

    // ----------------------------------------------------------------
    // polynomials and presets
    // ----------------------------------------------------------------
    localparam logic [15:0] POLY16       = 16'h1021;
    localparam logic [31:0] POLY32       = 32'h04c1_1db7;
    localparam logic [31:0] POLY32_REFL  = 32'hedb8_8320;
    localparam logic [31:0] PRESET_ZERO  = 32'h0000_0000;
    localparam logic [31:0] PRESET_ONES  = 32'hffff_ffff;
    localparam int          BITS_PER_CYC = 4;

    typedef enum logic [1:0] {
        CRCBE_LOW  = 2'b00,
        CRCBE_HIGH = 2'b01
    } crcbe_phase_t;

endpackage

// >>> crcbe_engine.sv
// byte-serial crc16/crc32 engine with bit-reverse register behind the sfr bus
`timescale 1ns/10ps
module crcbe_engine
    import crcbe_pkg::*;
#(
    parameter int DEPTH = 2,
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [WIDTH-1:0] sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    output logic                  sfr_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] fifo_mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [CW-1:0]    count_reg;
    crcbe_phase_t     phase_reg;
    logic [31:0]      result_reg;
    logic [31:0]      result_next;
    logic             sel_reg;
    logic             val_reg;
    logic [1:0]       ptr_reg;
    logic [7:0]       flip_reg;
    logic [7:0]       rdata_reg;
    logic [7:0]       head;
    logic             busy;
    logic             full;
    logic             hit_input;
    logic             hit_res;
    logic             take_wr;
    logic             take_rd;
    logic             push;
    logic             pop;
    logic             data_acc;
    logic [1:0]       byte_sel;
    logic [7:0]       cur_byte;

    // ----------------------------------------------------------------
    // crc step functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic m16);
        logic [15:0] c16;
        logic [31:0] r;
        c16 = c[15:0];
        r = c;
        if (m16) begin
            if (c16[15]) begin
                c16 = (c16 << 1) ^ POLY16;
            end else begin
                c16 = c16 << 1;
            end
            r = {c[31:16], c16};
        end else if (c[0]) begin
            r = (c >> 1) ^ POLY32_REFL;
        end else begin
            r = c >> 1;
        end
        return r;
    endfunction

    function automatic logic [31:0] crc_in(input logic [31:0] c, input logic m16,
                                           input logic [7:0] b);
        logic [31:0] r;
        r = m16 ? (c ^ {16'h0000, b, 8'h00}) : (c ^ {24'h00_0000, b});
        return r;
    endfunction

    function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic m16,
                                            input logic [7:0] b);
        logic [31:0] r;
        r = crc_in(c, m16, b);
        for (int i = 0; i < 8; i++) begin
            r = crc_bit(r, m16);
        end
        return r;
    endfunction

    function automatic logic [7:0] bit_rev(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // bus decode and hold-off
    // ----------------------------------------------------------------
    // result and control accesses wait until queued bytes are folded in
    assign busy      = (count_reg != '0);
    assign full      = (count_reg == CW'(DEPTH));
    assign hit_input = (sfr_addr == INPUT_ADDR);
    assign hit_res   = (sfr_addr == CTRL_ADDR) || (sfr_addr == DATA_ADDR);
    assign sfr_ready = hit_input ? !(sfr_wr && full) : !(hit_res && busy);
    assign take_wr   = sfr_wr && sfr_ready;
    assign take_rd   = sfr_rd && sfr_ready && !sfr_wr;
    assign push      = take_wr && hit_input;
    assign data_acc  = (take_wr || take_rd) && (sfr_addr == DATA_ADDR);
    assign byte_sel  = sel_reg ? {1'b0, ptr_reg[0]} : ptr_reg;
    assign head      = fifo_mem[rptr_reg];
    assign pop       = busy && (phase_reg == CRCBE_HIGH);
    assign sfr_rdata = rdata_reg;

    always_comb begin
        case (byte_sel)
            2'b00:   cur_byte = result_reg[7:0];
            2'b01:   cur_byte = result_reg[15:8];
            2'b10:   cur_byte = result_reg[23:16];
            default: cur_byte = result_reg[31:24];
        endcase
    end

    // ----------------------------------------------------------------
    // two-entry input buffer
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (push) begin
            fifo_mem[wptr_reg] <= sfr_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
            end
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end

    // ----------------------------------------------------------------
    // nibble-serial engine: two cycles per byte halves the xor depth
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_reg <= CRCBE_LOW;
        end else if (busy) begin
            phase_reg <= (phase_reg == CRCBE_LOW) ? CRCBE_HIGH : CRCBE_LOW;
        end else begin
            phase_reg <= CRCBE_LOW;
        end
    end

    always_comb begin
        result_next = result_reg;
        if (busy) begin
            if (phase_reg == CRCBE_LOW) begin
                result_next = crc_in(result_reg, sel_reg, head);
            end
            for (int i = 0; i < BITS_PER_CYC; i++) begin
                result_next = crc_bit(result_next, sel_reg);
            end
        end else if (take_wr && (sfr_addr == CTRL_ADDR) && sfr_wdata[INIT_BIT]) begin
            result_next = sfr_wdata[VAL_BIT] ? PRESET_ONES : PRESET_ZERO;
        end else if (take_wr && (sfr_addr == DATA_ADDR)) begin
            case (byte_sel)
                2'b00:   result_next[7:0]   = sfr_wdata;
                2'b01:   result_next[15:8]  = sfr_wdata;
                2'b10:   result_next[23:16] = sfr_wdata;
                default: result_next[31:24] = sfr_wdata;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_reg <= RESULT_RESET;
        end else begin
            result_reg <= result_next;
        end
    end

    // ----------------------------------------------------------------
    // control, pointer, bit-reverse and read data
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_reg <= CTRL_RESET[SEL_BIT];
            val_reg <= CTRL_RESET[VAL_BIT];
            ptr_reg <= CTRL_RESET[PTR_LSB+1:PTR_LSB];
        end else if (take_wr && (sfr_addr == CTRL_ADDR)) begin
            sel_reg <= sfr_wdata[SEL_BIT];
            val_reg <= sfr_wdata[VAL_BIT];
            ptr_reg <= sfr_wdata[PTR_LSB+1:PTR_LSB];
        end else if (data_acc) begin
            ptr_reg <= ptr_reg + 2'b01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flip_reg <= FLIP_RESET;
        end else if (take_wr && (sfr_addr == FLIP_ADDR)) begin
            flip_reg <= bit_rev(sfr_wdata);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= RDATA_RESET;
        end else if (take_rd) begin
            case (sfr_addr)
                CTRL_ADDR: rdata_reg <= {3'b000, sel_reg, 1'b0, val_reg, ptr_reg};
                DATA_ADDR: rdata_reg <= cur_byte;
                FLIP_ADDR: rdata_reg <= flip_reg;
                default:   rdata_reg <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [31:0] start_reg;
    always_ff @(posedge clock) begin
        if (busy && (phase_reg == CRCBE_LOW)) begin
            start_reg <= result_reg;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    crc32_byte_a: assert property (pop && !sel_reg |=>
        result_reg == crc_ref(start_reg, 1'b0, $past(head)))
        else $error("32-bit byte update wrong");
    crc16_byte_a: assert property (pop && sel_reg |=>
        result_reg == crc_ref(start_reg, 1'b1, $past(head)))
        else $error("16-bit byte update wrong");
    upper_hold_a: assert property (busy && sel_reg |=>
        result_reg[31:16] == $past(result_reg[31:16]))
        else $error("16-bit mode touched upper half");
    init_load_a: assert property (take_wr && sfr_addr == CTRL_ADDR && sfr_wdata[INIT_BIT]
        |=> result_reg == ($past(sfr_wdata[VAL_BIT]) ? PRESET_ONES : PRESET_ZERO))
        else $error("init did not load preset");
    ptr_step_a: assert property (data_acc |=> ptr_reg == $past(ptr_reg) + 2'b01)
        else $error("pointer did not increment");
    result_hold_a: assert property (!busy && !(take_wr && hit_res) |=> $stable(result_reg))
        else $error("result changed without cause");
    byte_write_a: assert property (take_wr && sfr_addr == DATA_ADDR && !sel_reg
        && ptr_reg == 2'b10 |=> result_reg[23:16] == $past(sfr_wdata)
        && result_reg[31:24] == $past(result_reg[31:24])
        && result_reg[15:0] == $past(result_reg[15:0]))
        else $error("result byte write wrong");
    read_map16_a: assert property (take_rd && sfr_addr == DATA_ADDR && sel_reg
        && ptr_reg == 2'b11 |=> sfr_rdata == $past(result_reg[15:8]))
        else $error("16-bit pointer map wrong");
    read_map32_a: assert property (take_rd && sfr_addr == DATA_ADDR && !sel_reg
        && ptr_reg == 2'b11 |=> sfr_rdata == $past(result_reg[31:24]))
        else $error("32-bit pointer map wrong");
    flip_back_a: assert property (take_wr && sfr_addr == FLIP_ADDR ##1
        take_rd && sfr_addr == FLIP_ADDR |=> sfr_rdata == bit_rev($past(sfr_wdata, 2)))
        else $error("bit reverse readback wrong");
    drain_time_a: assert property (push && count_reg == '0 ##1 !push [*2] |=> !busy)
        else $error("byte not folded in time");
    hold_off_a: assert property (busy && hit_res && (sfr_wr || sfr_rd) |-> !sfr_ready)
        else $error("result access during update");

    byte16_c: cover property (pop && sel_reg);
    byte32_c: cover property (pop && !sel_reg);
    fifo_full_c: cover property (full && sfr_wr && hit_input);
    init_c: cover property (take_wr && sfr_addr == CTRL_ADDR && sfr_wdata[INIT_BIT]);
endmodule

// >>> crcbe_cpu.sv
// processor-side bus model that drives the crc engine's register port
`timescale 1ns/10ps
module crcbe_cpu
    import crcbe_pkg::*;
(
    input  wire logic       clock,
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr,
    output logic            sfr_rd,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       sfr_ready,
    output logic            stuck
);
    initial begin
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_wdata = 8'h00;
        stuck     = 1'b0;
    end

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // entered at a falling edge; request stays put until the taking edge
    // ready is looked at on the rising edge, where the engine samples it too;
    // reading it right after the falling-edge change would see a stale value
    task automatic wait_take();
        int n;
        n = 0;
        @(posedge clock);
        while (sfr_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        if (n == 50) stuck = 1'b1;
        @(negedge clock);
    endtask

    // no release here, so back-to-back calls keep the bus busy
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_rd    = 1'b0;
        sfr_wr    = 1'b1;
        wait_take();
    endtask

    task automatic read(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_wr   = 1'b0;
        sfr_rd   = 1'b1;
        wait_take();
        d = sfr_rdata;
    endtask

    // ----------------------------------------------------------------
    // software sequences
    // ----------------------------------------------------------------
    // mode and preset chosen in the same write that pulses the trigger
    task automatic setup(input logic sel, input logic val);
        write(CTRL_ADDR, {3'b000, sel, 1'b1, val, 2'b00});
    endtask

    task automatic feed(input logic [7:0] b);
        write(INPUT_ADDR, b);
    endtask

    // released lines show the inverse so stale values cannot pass
    task automatic idle();
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_addr  = ~sfr_addr;
        sfr_wdata = ~sfr_wdata;
    endtask
endmodule

// >>> crcbe_tb.sv
// self-checking testbench for the byte-serial crc engine
`timescale 1ns/10ps
module tb;
    import crcbe_pkg::*;
    logic       clock;
    logic       rst_n;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       sfr_ready;
    logic       stuck;
    logic       sel;
    logic       val;
    int         n_mismatch;
    int         num_checks;
    int         cycles;

    always #20 clock = ~clock;

    crcbe_engine #(.DEPTH(2), .WIDTH(8)) i_dut (
        .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_ready(sfr_ready)
    );

    crcbe_cpu i_cpu (
        .clock(clock), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_ready(sfr_ready),
        .stuck(stuck)
    );

    // ----------------------------------------------------------------
    // checking and reporting
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_cpu.read(a, d);
        check(name, d, exp);
    endtask

    // pointer assumed at 0; bytes come out lowest first
    task automatic rd_result(input string name, input logic [31:0] exp);
        for (int i = 0; i < 4; i++) begin
            rd_check(name, DATA_ADDR, exp[8*i +: 8]);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // bounds the whole run at 5000 cycles; a hung handshake already gives up after 50 in wait_take
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    logic [7:0] flip_in  [3] = '{8'hc0, 8'h01, 8'h2d};
    logic [7:0] flip_out [3] = '{8'h03, 8'h80, 8'hb4};

    initial begin
        clock      = 1'b0;
        rst_n      = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        cycles     = 0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        rd_check("ctrl_reset", CTRL_ADDR, 8'h00);
        rd_result("result_reset", 32'h0000_0000);
        val = 1'b1;
        for (int m = 0; m < 2; m++) begin
            sel = m[0];
            i_cpu.setup(sel, val);
            i_cpu.feed(8'h63);
            rd_result("crc_one", sel ? 32'hbd35_bd35 : 32'hf946_2090);
            rd_check("ctrl_mode", CTRL_ADDR, {3'b000, sel, 1'b0, val, 2'b00});
            i_cpu.setup(sel, val);
            i_cpu.feed(8'haa);
            i_cpu.feed(8'hbb);
            i_cpu.feed(8'hcc);
            rd_result("crc_three", sel ? 32'h6cf6_6cf6 : 32'h41b2_07b3);
        end
        sel = 1'b0;
        val = 1'b0;
        i_cpu.setup(sel, val);
        rd_result("preset_zero", PRESET_ZERO);
        // all-ones background shows whether neighbouring bytes survive
        val = 1'b1;
        i_cpu.setup(sel, val);
        i_cpu.write(CTRL_ADDR, 8'h06);
        i_cpu.write(DATA_ADDR, 8'h5a);
        i_cpu.write(CTRL_ADDR, 8'h04);
        rd_result("byte_write", 32'hff5a_ffff);
        // second reset with non-zero control and result left behind
        i_cpu.idle();
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        rd_check("ctrl_rerun", CTRL_ADDR, CTRL_RESET);
        rd_result("result_rerun", RESULT_RESET);
        for (int i = 0; i < 3; i++) begin
            i_cpu.write(FLIP_ADDR, flip_in[i]);
            rd_check("bit_reverse", FLIP_ADDR, flip_out[i]);
        end
        rd_check("input_read", INPUT_ADDR, 8'h00);
        rd_check("unmapped", 8'h90, 8'h00);
        check("handshake", {7'h00, stuck}, 8'h00);
        i_cpu.idle();
        results();
    end
endmodule
